// ==== common/bmss_pkg.sv ====
/*
  package for the binary multi-speed select block: register map, field
  positions, reset values, input function codes and carrier structs.
  assumes an apb master with 32-bit data and word-aligned registers.
*/
package bmss_pkg;
  localparam int FREQ_W = 16;
  localparam int NUM_TERM = 5;
  localparam int NUM_PRESET = 16;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TERM_MAP = 8'h04;
  localparam logic [7:0] OFF_MAX_FREQ = 8'h08;
  localparam logic [7:0] OFF_EDIT_FREQ = 8'h0C;
  localparam logic [7:0] OFF_KEYS = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_MONITOR = 8'h18;
  localparam logic [7:0] OFF_EDIT_SLOT = 8'h1C;
  localparam logic [7:0] OFF_PRESET_BASE = 8'h40;
  localparam logic [7:0] OFF_PRESET_END = 8'h7C;

  // ctrl fields
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_ENC_LSB = 8;
  // keys fields (store: write one to press; run: holds the written bit)
  localparam int KEY_STORE_BIT = 0;
  localparam int KEY_RUN_BIT = 1;
  // status fields
  localparam int STAT_IDX_LSB = 0;
  localparam int STAT_OVR_BIT = 4;
  localparam int STAT_RUN_BIT = 5;
  localparam int STAT_NV_BIT = 6;

  // parameter codes
  localparam logic [7:0] SRC_TERMINAL = 8'h01;
  localparam logic [7:0] ENC_BINARY = 8'h00;
  // terminal function codes: binary select bits 0..3
  localparam logic [7:0] FN_SEL0 = 8'h02;

  localparam logic [7:0] RST_SRC = 8'h01;
  localparam logic [7:0] RST_ENC = 8'h00;
  localparam logic [39:0] RST_TERM_MAP = 40'h00_05_04_03_02;
  localparam logic [FREQ_W-1:0] RST_MAX_FREQ = 16'h1770;
  localparam logic [FREQ_W-1:0] RST_PRESET = 16'h0000;

  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } bmss_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } bmss_apb_rsp_t;

  typedef struct packed {
    logic [FREQ_W-1:0] freq;
    logic [3:0] idx;
    logic override;
  } bmss_sel_t;
endpackage

// ==== core/bmss_core.sv ====
/*
  binary multi-speed select: sixteen preset frequencies chosen by four
  binary select functions mapped onto five input terminals, override of
  the analog reference, preset programming by keypad or by select inputs.
  assumes terminals arrive asynchronously from switches or a plc, the
  analog reference is already a sampled word on clk_sys, and the
  nonvolatile store is an external write port taking one-cycle strobes.
*/
`timescale 1ns/1ps

// Behaviour
// - sixteen preset frequencies held in a table addressed by a 4-bit index
// - select bit one is index bit 0, bit four is index bit 3
// - each select function may sit on any of five terminals, any order
// - unassigned select bits read as zero, fewer inputs address fewer speeds
// - terminal source with no select active uses the analog reference
// - terminal source with any select active uses the indexed preset
// - a readable monitor shows the frequency currently in use
// - keypad edits commit to nonvolatile memory only on a store key press
// - in stop with a select active the display shows the addressed preset, otherwise edit_freq; store writes it there
module bmss_core
  import bmss_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire bmss_apb_req_t apb_req,
  output bmss_apb_rsp_t apb_rsp,
  input wire logic [NUM_TERM-1:0] term_in,
  input wire logic [FREQ_W-1:0] analog_ref,
  output logic [FREQ_W-1:0] output_frequency_monitor,
  output logic [FREQ_W-1:0] frequency_setting_display,
  output logic nv_wr,
  output logic [3:0] nv_addr,
  output logic [FREQ_W-1:0] nv_data
);

  typedef enum logic [1:0] {
    BMSS_IDLE = 2'b00,
    BMSS_COMMIT = 2'b01
  } bmss_state_t;

  logic [NUM_TERM-1:0] sync1;
  logic [NUM_TERM-1:0] sync2;
  logic [NUM_TERM-1:0] sync3;
  logic [NUM_TERM-1:0] term_level;
  logic [FREQ_W-1:0] preset_freq [NUM_PRESET];
  logic [7:0] frequency_source_select;
  logic [7:0] speed_select_encoding_mode;
  logic [39:0] term_map;
  logic [FREQ_W-1:0] max_freq;
  logic [FREQ_W-1:0] edit_freq;
  logic [3:0] edit_slot;
  logic run_cmd;
  bmss_state_t state;

  // the first sync stage is read only by the second
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      term_level <= '0;
    end
    else
    begin
      sync1 <= term_in;
      sync2 <= sync1;
      sync3 <= sync2;
      term_level <= (sync2 & sync3) | (term_level & (sync2 | sync3));
    end
  end

  // gather one select bit from whichever terminals carry its function code;
  // no terminal carrying it leaves the bit at zero
  function automatic logic sel_bit(input logic [39:0] map, input logic [NUM_TERM-1:0] lvl,
                                   input logic [1:0] b);
    logic r;
    r = 1'b0;
    for (int t = 0; t < NUM_TERM; t++)
      if (map[t*8 +: 8] == FN_SEL0 + 8'(b))
        r = r | lvl[t];
    return r;
  endfunction

  function automatic logic [FREQ_W-1:0] clamp(input logic [FREQ_W-1:0] f,
                                              input logic [FREQ_W-1:0] lim);
    return (f > lim) ? lim : f;
  endfunction

  wire binary_mode = (speed_select_encoding_mode == ENC_BINARY);
  wire terminal_src = (frequency_source_select == SRC_TERMINAL);
  wire [3:0] speed_index = binary_mode ?
    {sel_bit(term_map, term_level, 2'd3), sel_bit(term_map, term_level, 2'd2),
     sel_bit(term_map, term_level, 2'd1), sel_bit(term_map, term_level, 2'd0)}
    : 4'h0;
  wire any_sel = |speed_index;
  wire override = terminal_src && any_sel;
  wire [FREQ_W-1:0] preset_sel = clamp(preset_freq[speed_index], max_freq);
  wire [FREQ_W-1:0] ref_sel = clamp(analog_ref, max_freq);
  wire [FREQ_W-1:0] next_out = override ? preset_sel : ref_sel;
  // stopped with a select active, the addressed preset is edited
  wire select_edit = !run_cmd && any_sel;
  wire [3:0] target_slot = select_edit ? speed_index : edit_slot;

  // apb decode
  wire setup = apb_req.psel && !apb_req.penable;
  wire wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
  wire [7:0] addr = apb_req.paddr;
  wire is_preset = (addr >= OFF_PRESET_BASE) && (addr <= OFF_PRESET_END) && (addr[1:0] == 2'b00);
  wire [3:0] preset_idx = addr[5:2];
  wire known = is_preset || addr == OFF_CTRL || addr == OFF_TERM_MAP ||
               addr == OFF_MAX_FREQ || addr == OFF_EDIT_FREQ || addr == OFF_KEYS ||
               addr == OFF_STATUS || addr == OFF_MONITOR || addr == OFF_EDIT_SLOT;
  wire store_press = wr_acc && addr == OFF_KEYS && apb_req.pwdata[KEY_STORE_BIT];
  logic [31:0] rd_word;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (is_preset)
      rd_word = {16'h0000, preset_freq[preset_idx]};
    else
      case (addr)
        OFF_CTRL: rd_word = {16'h0000, speed_select_encoding_mode, frequency_source_select};
        OFF_TERM_MAP: rd_word = term_map[31:0];
        OFF_MAX_FREQ: rd_word = {16'h0000, max_freq};
        OFF_EDIT_FREQ: rd_word = {16'h0000, edit_freq};
        OFF_KEYS: rd_word = {30'h0, run_cmd, 1'b0};
        OFF_STATUS: rd_word = {25'h0, state == BMSS_COMMIT, run_cmd, override, speed_index};
        OFF_MONITOR: rd_word = {16'h0000, output_frequency_monitor};
        OFF_EDIT_SLOT: rd_word = {20'h0, term_map[39:32], edit_slot};
        default: rd_word = 32'h0000_0000;
      endcase
  end

  // no wait state: setup registers the answer, the first access cycle returns it
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      apb_rsp <= '0;
    else if (setup)
    begin
      apb_rsp.prdata <= apb_req.pwrite ? 32'h0000_0000 : rd_word;
      apb_rsp.pslverr <= !known;
      apb_rsp.pready <= 1'b1;
    end
    else
      apb_rsp <= '0;
  end

  wire wr_take = wr_acc && apb_rsp.pready && known;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      frequency_source_select <= RST_SRC;
      speed_select_encoding_mode <= RST_ENC;
      term_map <= RST_TERM_MAP;
      max_freq <= RST_MAX_FREQ;
      edit_freq <= RST_PRESET;
      edit_slot <= 4'h0;
      run_cmd <= 1'b0;
    end
    else if (wr_take)
    begin
      case (addr)
        OFF_CTRL:
        begin
          frequency_source_select <= apb_req.pwdata[CTRL_SRC_LSB +: 8];
          speed_select_encoding_mode <= apb_req.pwdata[CTRL_ENC_LSB +: 8];
        end
        OFF_TERM_MAP: term_map[31:0] <= apb_req.pwdata;
        OFF_MAX_FREQ: max_freq <= apb_req.pwdata[FREQ_W-1:0];
        OFF_EDIT_FREQ: edit_freq <= apb_req.pwdata[FREQ_W-1:0];
        OFF_KEYS: run_cmd <= apb_req.pwdata[KEY_RUN_BIT];
        OFF_EDIT_SLOT:
        begin
          edit_slot <= apb_req.pwdata[3:0];
          term_map[39:32] <= apb_req.pwdata[11:4];
        end
        default: run_cmd <= run_cmd;
      endcase
    end
  end

  // presets change only on a store press or a direct preset write, never on an edit write
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < NUM_PRESET; i++)
        preset_freq[i] <= RST_PRESET;
    end
    else if (wr_take && is_preset)
      preset_freq[preset_idx] <= apb_req.pwdata[FREQ_W-1:0];
    else if (wr_take && store_press)
      preset_freq[target_slot] <= edit_freq;
  end

  // a store press hands the edited value to the nonvolatile port
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= BMSS_IDLE;
      nv_wr <= 1'b0;
      nv_addr <= 4'h0;
      nv_data <= RST_PRESET;
    end
    else
    begin
      case (state)
        BMSS_IDLE:
          if (wr_take && (store_press || is_preset))
          begin
            state <= BMSS_COMMIT;
            nv_wr <= 1'b1;
            nv_addr <= is_preset ? preset_idx : target_slot;
            nv_data <= is_preset ? apb_req.pwdata[FREQ_W-1:0] : edit_freq;
          end
        BMSS_COMMIT:
        begin
          state <= BMSS_IDLE;
          nv_wr <= 1'b0;
        end
        default:
        begin
          state <= BMSS_IDLE;
          nv_wr <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      output_frequency_monitor <= RST_PRESET;
      frequency_setting_display <= RST_PRESET;
    end
    else
    begin
      output_frequency_monitor <= next_out;
      frequency_setting_display <= select_edit ? preset_freq[speed_index] : edit_freq;
    end
  end

endmodule

// ==== sim/bmss_asserts.sv ====
/* checker for bmss_core, watching its apb and commit ports only.
   assumes one clock domain and the two-cycle apb answer of the core. */
`timescale 1ns/1ps
module bmss_asserts
  import bmss_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire bmss_apb_req_t apb_req,
  input wire bmss_apb_rsp_t apb_rsp,
  input wire logic nv_wr,
  input wire logic [3:0] nv_addr,
  input wire logic [FREQ_W-1:0] nv_data
);
  wire setup = apb_req.psel && !apb_req.penable;
  wire wr_done = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready;
  // an unaligned address inside the preset window is refused, so it must not count as a hit
  wire pre_hit = apb_req.paddr >= OFF_PRESET_BASE && apb_req.paddr <= OFF_PRESET_END &&
                 apb_req.paddr[1:0] == 2'b00;
  logic [3:0] last_idx;
  logic [FREQ_W-1:0] last_dat;
  // capture the preset write so the commit port can be compared a cycle or two later
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      last_idx <= 4'h0;
      last_dat <= '0;
    end
    else if (wr_done && pre_hit)
    begin
      last_idx <= apb_req.paddr[5:2];
      last_dat <= apb_req.pwdata[FREQ_W-1:0];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence store_press;
    wr_done && apb_req.paddr == OFF_KEYS && apb_req.pwdata[KEY_STORE_BIT];
  endsequence
  sequence nv_pulse;
    nv_wr ##1 !nv_wr;
  endsequence
  a_ready_after_setup: assert property (setup |=> apb_rsp.pready)
    else $error("no ready after setup");
  a_ready_in_access: assert property (apb_rsp.pready |-> apb_req.psel && apb_req.penable)
    else $error("ready outside access");
  a_ready_one_cycle: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("ready too long");
  a_store_commits: assert property (store_press |-> ##[1:2] nv_pulse)
    else $error("store key did not commit");
  a_preset_commits: assert property (wr_done && pre_hit |-> ##[1:2]
    (nv_wr && nv_addr == last_idx && nv_data == last_dat)) else $error("preset commit wrong");
  a_commit_cause: assert property (nv_wr |-> $past(wr_done) || $past(wr_done, 2))
    else $error("commit without a write");
  a_err_no_commit: assert property (wr_done && apb_rsp.pslverr |=> !nv_wr [*2])
    else $error("refused write committed");
  a_commit_hold: assert property (!nv_wr |-> $stable(nv_addr) && $stable(nv_data))
    else $error("commit port moved");
endmodule

// ==== sim/bmss_switch_bank.sv ====
/* far side: a bank of clean switches driving the five input terminals.
   assumes the bench sets the wanted pattern right after a clock edge. */
`timescale 1ns/1ps
module bmss_switch_bank
  import bmss_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [NUM_TERM-1:0] want,
  output logic [NUM_TERM-1:0] term_in
);
  // no bounce modelled, the core's agree filter is not the subject here
  always_ff @(posedge clk_sys)
  begin
    term_in <= want;
  end
endmodule

// ==== sim/tb_top.sv ====
/* self-checking bench for bmss_core: apb tasks, switch bank on the
   terminals, expectations from the preset values written here. */
`timescale 1ns/1ps
module tb_top
  import bmss_pkg::*;
;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  bmss_apb_req_t req = '0;
  bmss_apb_rsp_t rsp;
  logic [NUM_TERM-1:0] want = '0;
  logic [NUM_TERM-1:0] term_in;
  logic [FREQ_W-1:0] analog_ref = 16'h0ABC;
  logic [FREQ_W-1:0] mon;
  logic [FREQ_W-1:0] disp;
  logic [3:0] nv_addr;
  logic [FREQ_W-1:0] nv_data;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;
  bmss_core dut (.clk_sys(clk_sys), .arst_n(arst_n), .apb_req(req), .apb_rsp(rsp),
    .term_in(term_in), .analog_ref(analog_ref), .output_frequency_monitor(mon),
    .frequency_setting_display(disp), .nv_wr(), .nv_addr(nv_addr), .nv_data(nv_data));
  bmss_switch_bank far (.clk_sys(clk_sys), .want(want), .term_in(term_in));
  initial
  begin
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    @(posedge clk_sys);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
    end
    while (rsp.pready !== 1'b1);
    r = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(a, 1'b1, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    xfer(a, 1'b0, '0, r, e);
    chk(r, exp);
  endtask
  // switches settle through sync and filter before the monitor is judged
  task automatic sel(input logic [4:0] p, input logic [31:0] exp);
    want <= p;
    repeat (10) @(posedge clk_sys);
    chk(32'(mon), exp);
    rd(OFF_MONITOR, exp);
  endtask
  task automatic tally_and_finish();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial
  begin
    logic [31:0] r;
    logic e;
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(OFF_CTRL, 32'h00000001);
    rd(OFF_TERM_MAP, 32'h05040302);
    rd(OFF_MAX_FREQ, 32'h00001770);
    for (int i = 0; i < NUM_PRESET; i++)
      wr(8'(OFF_PRESET_BASE + 4 * i), 32'(i * 32'h0111));
    rd(OFF_PRESET_END, 32'h00000FFF);
    sel(5'h00, 32'h00000ABC);
    for (int i = 1; i < NUM_PRESET; i++)
      sel(5'(i), 32'(i * 32'h0111));
    wr(OFF_TERM_MAP, 32'h00040305);
    wr(OFF_EDIT_SLOT, 32'h00000020);
    sel(5'b11011, 32'h00000BBB);
    wr(OFF_MAX_FREQ, 32'h00000500);
    sel(5'b11011, 32'h00000500);
    wr(OFF_CTRL, 32'h00000101);
    analog_ref <= 16'h0123;
    sel(5'b11011, 32'h00000123);
    wr(OFF_CTRL, 32'h00000001);
    wr(OFF_MAX_FREQ, 32'h00001770);
    wr(OFF_TERM_MAP, 32'h00040302);
    sel(5'b11111, 32'h00000777);
    wr(OFF_TERM_MAP, 32'h05040302);
    wr(OFF_EDIT_SLOT, 32'h00000000);
    wr(OFF_KEYS, 32'h00000000);
    sel(5'b00101, 32'h00000555);
    chk(32'(disp), 32'h00000555);
    wr(OFF_EDIT_FREQ, 32'h00000321);
    rd(8'(OFF_PRESET_BASE + 8'h14), 32'h00000555);
    wr(OFF_KEYS, 32'h00000001);
    rd(8'(OFF_PRESET_BASE + 8'h14), 32'h00000321);
    repeat (3) @(posedge clk_sys);
    chk(32'(disp), 32'h00000321);
    chk(32'(nv_addr), 32'h00000005);
    chk(32'(nv_data), 32'h00000321);
    rd(OFF_STATUS, 32'h00000015);
    wr(OFF_EDIT_FREQ, 32'h00000246);
    wr(OFF_KEYS, 32'h00000002);
    repeat (2) @(posedge clk_sys);
    chk(32'(disp), 32'h00000246);
    wr(OFF_KEYS, 32'h00000003);
    xfer(8'h41, 1'b1, 32'h00000999, r, e);
    chk(32'(e), 32'h00000001);
    rd(OFF_PRESET_BASE, 32'h00000246);
    xfer(8'h30, 1'b0, '0, r, e);
    chk(r, 32'h00000000);
    chk(32'(e), 32'h00000001);
    tally_and_finish();
  end
endmodule
bind bmss_core bmss_asserts chk_u (.clk_sys(clk_sys), .arst_n(arst_n),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .nv_wr(nv_wr), .nv_addr(nv_addr),
  .nv_data(nv_data));
